// File: override_ctrl_pkg.sv
// constants for the host override control register bank
`default_nettype none
package override_ctrl_pkg;
  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FET_MON_CTRL_OFFSET = 8'h86;
  localparam logic [7:0] AUTONOMY_CTRL_OFFSET = 8'h87;
  localparam logic [7:0] FET_MON_CTRL_RESET = 8'h00;
  localparam logic [7:0] AUTONOMY_CTRL_RESET = 8'h00;
  // ----------------------------------------------------------------
  // field positions, first control register
  // ----------------------------------------------------------------
  localparam int LOAD_ERROR_CLEAR_BIT = 7;
  localparam int LOAD_MONITOR_TRIGGER_BIT = 6;
  localparam int CHARGER_ERROR_CLEAR_BIT = 5;
  localparam int CHARGER_MONITOR_TRIGGER_BIT = 4;
  localparam int PACK_SHUTDOWN_BIT = 3;
  localparam int PRECHARGE_BIT = 2;
  localparam int CHARGE_BIT = 1;
  localparam int DISCHARGE_BIT = 0;
  // ----------------------------------------------------------------
  // field positions, second control register
  // ----------------------------------------------------------------
  localparam int RESERVED_BIT = 7;
  localparam int SWITCH_OVERRIDE_BIT = 6;
  localparam int BALANCE_OVERRIDE_BIT = 5;
  localparam int LOAD_MONITOR_OVERRIDE_BIT = 4;
  localparam int CHARGER_MONITOR_OVERRIDE_BIT = 3;
  localparam int SCAN_OVERRIDE_BIT = 2;
  localparam int OPEN_WIRE_START_BIT = 1;
  localparam int BALANCE_ON_BIT = 0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RECOVERY_PULSE_NS = 1000;
  localparam int RECOVERY_PULSE_CYCLES = (RECOVERY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // monitor channel sequence
  typedef enum logic [1:0] {MON_IDLE, MON_PULSE, MON_SAMPLE} monitor_state_t;
endpackage : override_ctrl_pkg
`default_nettype wire

// File: monitor_channel.sv
// one load or charger monitor channel with host-triggered recovery pulse
`timescale 1ns/100ps
`default_nettype none
module monitor_channel
#(
  parameter int unsigned PULSE_CYCLES = override_ctrl_pkg::RECOVERY_PULSE_CYCLES
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic override,
  input wire logic trigger,
  input wire logic stop,
  input wire logic error_clear,
  input wire logic sense_sync,
  input wire logic auto_on,
  input wire logic auto_present,
  output logic monitor_on_r,
  output logic recovery_pulse_r,
  output logic present_r,
  output logic busy_r
);
  localparam int CW = $clog2(PULSE_CYCLES + 1);

  // pulse width below one cycle cannot be produced
  if (PULSE_CYCLES < 1)
  begin : g_bad_pulse
    $error("PULSE_CYCLES must be at least 1");
  end

  override_ctrl_pkg::monitor_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  wire start = override && trigger && (state_r == override_ctrl_pkg::MON_IDLE);

  // ----------------------------------------------------------------
  // recovery pulse sequencer
  // ----------------------------------------------------------------
  // a trigger while busy is dropped; the busy read-back tells the host
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      override_ctrl_pkg::MON_IDLE:
        if (start)
        begin
          state_nxt = override_ctrl_pkg::MON_PULSE;
          cnt_nxt = CW'(PULSE_CYCLES - 1);
        end
      override_ctrl_pkg::MON_PULSE:
        if (cnt_r == '0)
          state_nxt = override_ctrl_pkg::MON_SAMPLE;
        else
          cnt_nxt = cnt_r - 1'b1;
      override_ctrl_pkg::MON_SAMPLE:
        state_nxt = override_ctrl_pkg::MON_IDLE;
      default:
        state_nxt = override_ctrl_pkg::MON_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= override_ctrl_pkg::MON_IDLE;
      cnt_r <= '0;
      recovery_pulse_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      recovery_pulse_r <= (state_nxt == override_ctrl_pkg::MON_PULSE);
      busy_r <= (state_nxt != override_ctrl_pkg::MON_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // monitor power and presence flag
  // ----------------------------------------------------------------
  // without override the core's automatic monitor owns both
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      monitor_on_r <= 1'b0;
      present_r <= 1'b0;
    end
    else if (!override)
    begin
      monitor_on_r <= auto_on;
      present_r <= auto_present;
    end
    else
    begin
      if (trigger)
        monitor_on_r <= 1'b1;
      else if (stop)
        monitor_on_r <= 1'b0;
      if (state_r == override_ctrl_pkg::MON_SAMPLE)
        present_r <= sense_sync; // sample wins over a clear
      else if (error_clear)
        present_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [CW:0] pulse_len_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pulse_len_r <= '0;
    else if (recovery_pulse_r)
      pulse_len_r <= pulse_len_r + 1'b1;
    else
      pulse_len_r <= '0;
  end

  pulse_width_a: assert property ($fell(recovery_pulse_r) |-> pulse_len_r == (CW+1)'(PULSE_CYCLES))
    else $error("recovery pulse width wrong");
  sample_update_a: assert property (state_r == override_ctrl_pkg::MON_SAMPLE && override
    |=> present_r == $past(sense_sync))
    else $error("presence flag not updated after pulse");
  error_clear_a: assert property (override && error_clear && state_r != override_ctrl_pkg::MON_SAMPLE
    |=> !present_r)
    else $error("error clear did not reset presence");
  trigger_seq_c: cover property (start ##1 recovery_pulse_r ##[1:300] state_r == override_ctrl_pkg::MON_SAMPLE);
endmodule : monitor_channel
`default_nettype wire

// File: host_override_control.sv
// host override control registers: monitor triggers, power switch drive, autonomy overrides
// Behaviour
// - load, charger and switch bits act only under their matching override enables
// - load error clear resets load presence, self-clears, needs load monitor override
// - load monitor trigger turns monitor on, pulses recovery once, updates presence
// - charger error clear resets charger presence, self-clears, needs charger override
// - charger monitor trigger turns monitor on, pulses recovery, updates presence
// - pack shutdown bit drives the pack shutdown pin directly
// - automatic shutdown also sets the pack shutdown bit when its option is on
// - precharge bit switches the precharge drive
// - precharge bit cleared on charge, discharge overcurrent or short unless overridden
// - charge bit switches the charge drive
// - charge bit cleared on charge overcurrent or short unless overridden
// - discharge bit switches the discharge drive
// - discharge bit cleared on discharge overcurrent or short unless overridden
// - short circuit forces switches off even under host override
// - second register layout: reserved, overrides, open-wire start, balance on
// - without switch override switches run automatically, with it host bits govern
// - listed faults, sleep and switches-off input always force switches off
// - open-wire start launches scan, reads one while running, clears on completion
// - watchdog resets scan override; auto scans resume after next bus transaction
`timescale 1ns/100ps
`default_nettype none
module host_override_control
#(
  parameter int unsigned PULSE_CYCLES = override_ctrl_pkg::RECOVERY_PULSE_CYCLES
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic i2c_transaction,
  input wire logic watchdog_expired,
  input wire logic charge_overcurrent,
  input wire logic discharge_overcurrent,
  input wire logic discharge_short_circuit,
  input wire logic open_wire_fault,
  input wire logic internal_overtemp,
  input wire logic overvoltage_lockout,
  input wire logic undervoltage_lockout,
  input wire logic sleep_mode,
  input wire logic cell_failure,
  input wire logic cell_failure_shutdown_enable,
  input wire logic open_wire_shutdown_enable,
  input wire logic overvoltage_shutdown_enable,
  input wire logic auto_precharge_req,
  input wire logic auto_charge_req,
  input wire logic auto_discharge_req,
  input wire logic auto_load_monitor_on,
  input wire logic auto_load_present,
  input wire logic auto_charger_monitor_on,
  input wire logic auto_charger_present,
  input wire logic open_wire_host_enable,
  input wire logic open_wire_scan_done,
  input wire logic switches_off_input,
  input wire logic load_sense_pin,
  input wire logic charger_sense_pin,
  output logic precharge_switch_drive,
  output logic charge_switch_drive,
  output logic discharge_switch_drive,
  output logic pack_shutdown_out,
  output logic load_monitor_on,
  output logic load_recovery_pulse,
  output logic load_present_flag,
  output logic charger_monitor_on,
  output logic charger_recovery_pulse,
  output logic charger_present_flag,
  output logic auto_scan_enable,
  output logic open_wire_scan_req,
  output logic host_balance_override,
  output logic host_balance_active
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // switch drive: host or automatic request, always gated by hard faults
  function automatic logic switch_drive(input logic ovr, input logic host_bit,
                                        input logic auto_req, input logic forced);
    switch_drive = (ovr ? host_bit : auto_req) && !forced;
  endfunction : switch_drive

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // pins are asynchronous; stage one feeds stage two only
  logic [2:0] pin_meta_r, pin_sync_r;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end
    else
    begin
      pin_meta_r <= {switches_off_input, charger_sense_pin, load_sense_pin};
      pin_sync_r <= pin_meta_r;
    end
  end
  wire switches_off_sync = pin_sync_r[2];

  // ----------------------------------------------------------------
  // register state and decode
  // ----------------------------------------------------------------
  logic psd_r, precharge_r, charge_r, discharge_r;
  logic switch_ovr_r, balance_ovr_r, load_ovr_r, charger_ovr_r, scan_ovr_r;
  logic open_wire_r, balance_on_r, scan_hold_r;
  logic load_busy, charger_busy;

  wire wr_ctrl1 = reg_wr_en && (reg_addr == override_ctrl_pkg::FET_MON_CTRL_OFFSET);
  wire wr_ctrl2 = reg_wr_en && (reg_addr == override_ctrl_pkg::AUTONOMY_CTRL_OFFSET);
  wire load_trig = wr_ctrl1 && reg_wdata[override_ctrl_pkg::LOAD_MONITOR_TRIGGER_BIT];
  wire load_stop = wr_ctrl1 && !reg_wdata[override_ctrl_pkg::LOAD_MONITOR_TRIGGER_BIT];
  wire load_clr = wr_ctrl1 && reg_wdata[override_ctrl_pkg::LOAD_ERROR_CLEAR_BIT];
  wire chg_trig = wr_ctrl1 && reg_wdata[override_ctrl_pkg::CHARGER_MONITOR_TRIGGER_BIT];
  wire chg_stop = wr_ctrl1 && !reg_wdata[override_ctrl_pkg::CHARGER_MONITOR_TRIGGER_BIT];
  wire chg_clr = wr_ctrl1 && reg_wdata[override_ctrl_pkg::CHARGER_ERROR_CLEAR_BIT];

  // hardware fault terms
  wire short_hit = discharge_short_circuit;
  wire forced_off = short_hit || open_wire_fault || internal_overtemp || overvoltage_lockout
                    || undervoltage_lockout || sleep_mode || switches_off_sync;
  wire clr_precharge = !switch_ovr_r && (charge_overcurrent || discharge_overcurrent || short_hit);
  wire clr_charge = !switch_ovr_r && (charge_overcurrent || short_hit);
  wire clr_discharge = !switch_ovr_r && (discharge_overcurrent || short_hit);
  wire auto_shutdown = (cell_failure && cell_failure_shutdown_enable)
                       || (open_wire_fault && open_wire_shutdown_enable)
                       || (overvoltage_lockout && overvoltage_shutdown_enable);
  wire ow_allowed = open_wire_host_enable || scan_ovr_r;
  wire ow_launch = wr_ctrl2 && reg_wdata[override_ctrl_pkg::OPEN_WIRE_START_BIT] && ow_allowed && !open_wire_r;

  // ----------------------------------------------------------------
  // first control register: shutdown and switch bits
  // ----------------------------------------------------------------
  // fault clear beats a host write of one; safety before software
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      psd_r <= override_ctrl_pkg::FET_MON_CTRL_RESET[override_ctrl_pkg::PACK_SHUTDOWN_BIT];
      precharge_r <= override_ctrl_pkg::FET_MON_CTRL_RESET[override_ctrl_pkg::PRECHARGE_BIT];
      charge_r <= override_ctrl_pkg::FET_MON_CTRL_RESET[override_ctrl_pkg::CHARGE_BIT];
      discharge_r <= override_ctrl_pkg::FET_MON_CTRL_RESET[override_ctrl_pkg::DISCHARGE_BIT];
    end
    else
    begin
      if (auto_shutdown)
        psd_r <= 1'b1; // set wins over a host clear
      else if (wr_ctrl1)
        psd_r <= reg_wdata[override_ctrl_pkg::PACK_SHUTDOWN_BIT];
      if (clr_precharge)
        precharge_r <= 1'b0;
      else if (wr_ctrl1)
        precharge_r <= reg_wdata[override_ctrl_pkg::PRECHARGE_BIT];
      if (clr_charge)
        charge_r <= 1'b0;
      else if (wr_ctrl1)
        charge_r <= reg_wdata[override_ctrl_pkg::CHARGE_BIT];
      if (clr_discharge)
        discharge_r <= 1'b0;
      else if (wr_ctrl1)
        discharge_r <= reg_wdata[override_ctrl_pkg::DISCHARGE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // second control register and scan hold
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      switch_ovr_r <= override_ctrl_pkg::AUTONOMY_CTRL_RESET[override_ctrl_pkg::SWITCH_OVERRIDE_BIT];
      balance_ovr_r <= override_ctrl_pkg::AUTONOMY_CTRL_RESET[override_ctrl_pkg::BALANCE_OVERRIDE_BIT];
      load_ovr_r <= override_ctrl_pkg::AUTONOMY_CTRL_RESET[override_ctrl_pkg::LOAD_MONITOR_OVERRIDE_BIT];
      charger_ovr_r <= override_ctrl_pkg::AUTONOMY_CTRL_RESET[override_ctrl_pkg::CHARGER_MONITOR_OVERRIDE_BIT];
      balance_on_r <= override_ctrl_pkg::AUTONOMY_CTRL_RESET[override_ctrl_pkg::BALANCE_ON_BIT];
    end
    else if (wr_ctrl2)
    begin
      switch_ovr_r <= reg_wdata[override_ctrl_pkg::SWITCH_OVERRIDE_BIT];
      balance_ovr_r <= reg_wdata[override_ctrl_pkg::BALANCE_OVERRIDE_BIT];
      load_ovr_r <= reg_wdata[override_ctrl_pkg::LOAD_MONITOR_OVERRIDE_BIT];
      charger_ovr_r <= reg_wdata[override_ctrl_pkg::CHARGER_MONITOR_OVERRIDE_BIT];
      balance_on_r <= reg_wdata[override_ctrl_pkg::BALANCE_ON_BIT];
    end
  end

  // watchdog beats both a host write and a bus transaction in the same cycle
  wire scan_ovr_nxt = watchdog_expired ? 1'b0
                      : (wr_ctrl2 ? reg_wdata[override_ctrl_pkg::SCAN_OVERRIDE_BIT] : scan_ovr_r);
  wire scan_hold_nxt = watchdog_expired ? 1'b1 : (i2c_transaction ? 1'b0 : scan_hold_r);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      scan_ovr_r <= override_ctrl_pkg::AUTONOMY_CTRL_RESET[override_ctrl_pkg::SCAN_OVERRIDE_BIT];
      scan_hold_r <= 1'b0;
      auto_scan_enable <= 1'b0;
      open_wire_r <= override_ctrl_pkg::AUTONOMY_CTRL_RESET[override_ctrl_pkg::OPEN_WIRE_START_BIT];
      open_wire_scan_req <= 1'b0;
    end
    else
    begin
      scan_ovr_r <= scan_ovr_nxt;
      scan_hold_r <= scan_hold_nxt;
      auto_scan_enable <= !scan_ovr_nxt && !scan_hold_nxt;
      if (ow_launch)
        open_wire_r <= 1'b1;
      else if (open_wire_scan_done)
        open_wire_r <= 1'b0;
      open_wire_scan_req <= ow_launch; // one-cycle launch strobe
    end
  end

  // ----------------------------------------------------------------
  // monitor channels
  // ----------------------------------------------------------------
  monitor_channel #(.PULSE_CYCLES(PULSE_CYCLES)) u_load_mon (
    .clk(clk),
    .sys_rst(sys_rst),
    .override(load_ovr_r),
    .trigger(load_trig),
    .stop(load_stop),
    .error_clear(load_clr),
    .sense_sync(pin_sync_r[0]),
    .auto_on(auto_load_monitor_on),
    .auto_present(auto_load_present),
    .monitor_on_r(load_monitor_on),
    .recovery_pulse_r(load_recovery_pulse),
    .present_r(load_present_flag),
    .busy_r(load_busy)
  );

  monitor_channel #(.PULSE_CYCLES(PULSE_CYCLES)) u_charger_mon (
    .clk(clk),
    .sys_rst(sys_rst),
    .override(charger_ovr_r),
    .trigger(chg_trig),
    .stop(chg_stop),
    .error_clear(chg_clr),
    .sense_sync(pin_sync_r[1]),
    .auto_on(auto_charger_monitor_on),
    .auto_present(auto_charger_present),
    .monitor_on_r(charger_monitor_on),
    .recovery_pulse_r(charger_recovery_pulse),
    .present_r(charger_present_flag),
    .busy_r(charger_busy)
  );

  // ----------------------------------------------------------------
  // outputs and read-back
  // ----------------------------------------------------------------
  // clear bits read zero; trigger bits read one only while the pulse or the sample cycle after it runs
  wire [7:0] ctrl1_view = {1'b0, load_busy, 1'b0, charger_busy, psd_r, precharge_r, charge_r, discharge_r};
  wire [7:0] ctrl2_view = {1'b0, switch_ovr_r, balance_ovr_r, load_ovr_r, charger_ovr_r,
                           scan_ovr_r, open_wire_r, balance_on_r};
  wire [7:0] read_mux = (reg_addr == override_ctrl_pkg::FET_MON_CTRL_OFFSET) ? ctrl1_view
                        : (reg_addr == override_ctrl_pkg::AUTONOMY_CTRL_OFFSET) ? ctrl2_view : 8'h00;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 8'h00;
      precharge_switch_drive <= 1'b0;
      charge_switch_drive <= 1'b0;
      discharge_switch_drive <= 1'b0;
      host_balance_override <= 1'b0;
      host_balance_active <= 1'b0;
    end
    else
    begin
      if (reg_rd_en)
        reg_rdata <= read_mux;
      precharge_switch_drive <= switch_drive(switch_ovr_r, precharge_r, auto_precharge_req, forced_off);
      charge_switch_drive <= switch_drive(switch_ovr_r, charge_r, auto_charge_req, forced_off);
      discharge_switch_drive <= switch_drive(switch_ovr_r, discharge_r, auto_discharge_req, forced_off);
      host_balance_override <= balance_ovr_r;
      host_balance_active <= balance_ovr_r && balance_on_r; // balance on only under override
    end
  end
  assign pack_shutdown_out = psd_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  short_off_a: assert property (short_hit |=> !precharge_switch_drive && !charge_switch_drive
    && !discharge_switch_drive)
    else $error("short circuit did not force switches off");
  forced_off_a: assert property (forced_off |=> !charge_switch_drive && !discharge_switch_drive)
    else $error("forcing condition left a switch on");
  auto_shutdown_a: assert property (auto_shutdown |=> pack_shutdown_out)
    else $error("automatic shutdown did not set pack shutdown");
  host_switch_a: assert property (switch_ovr_r && !forced_off |=> charge_switch_drive == $past(charge_r))
    else $error("host charge bit not followed under override");
  auto_switch_a: assert property (!switch_ovr_r && !forced_off
    |=> discharge_switch_drive == $past(auto_discharge_req))
    else $error("automatic discharge request not followed");
  charge_clear_a: assert property (charge_overcurrent && !switch_ovr_r |=> !charge_r)
    else $error("charge bit survived charge overcurrent");
  discharge_clear_a: assert property (discharge_overcurrent && !switch_ovr_r |=> !discharge_r)
    else $error("discharge bit survived discharge overcurrent");
  precharge_clear_a: assert property ((charge_overcurrent || short_hit) && !switch_ovr_r |=> !precharge_r)
    else $error("precharge bit survived fault");
  scan_watchdog_a: assert property (watchdog_expired |=> !scan_ovr_r && !auto_scan_enable)
    else $error("watchdog left scans running");
  scan_hold_a: assert property (scan_hold_r && !i2c_transaction |=> !auto_scan_enable)
    else $error("scans resumed without a bus transaction");
  open_wire_a: assert property (ow_launch |=> open_wire_r && open_wire_scan_req ##1 !open_wire_scan_req)
    else $error("open-wire launch not shown");
  reserved_read_a: assert property (reg_rd_en && reg_addr == override_ctrl_pkg::AUTONOMY_CTRL_OFFSET
    |=> !reg_rdata[override_ctrl_pkg::RESERVED_BIT])
    else $error("reserved bit read as one");

  host_fet_c: cover property (wr_ctrl2 ##1 switch_ovr_r ##[1:10] charge_switch_drive);
  short_c: cover property (switch_ovr_r && charge_r && short_hit);
  open_wire_c: cover property (ow_launch ##[1:100] open_wire_scan_done);
endmodule : host_override_control
`default_nettype wire

// File: host_model.sv
// host microcontroller model driving the register byte strobes
`timescale 1ns/100ps
`default_nettype none
module host_model
(
  input wire logic clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  // bus idles with both strobes low until the first access
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one byte per strobe; released address and data show the inverse of the task arguments, not of the masked 8'h87 byte
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr_en = wr;
    reg_rd_en = !wr;
    reg_addr = a;
    reg_wdata = (a == 8'h87) ? (d & 8'h7F) : d;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : access
endmodule : host_model
`default_nettype wire

// File: host_override_control_bench.sv
// bench: register bank under the host model, checked against fixed expected values
`timescale 1ns/100ps
`default_nettype none
module host_override_control_bench;
  logic clk=0, sys_rst=1, i2c_transaction=0, watchdog_expired=0, charge_overcurrent=0, discharge_overcurrent=0,
    discharge_short_circuit=0, open_wire_fault=0, internal_overtemp=0, overvoltage_lockout=0, undervoltage_lockout=0,
    sleep_mode=0, cell_failure=0, cell_failure_shutdown_enable=0, open_wire_shutdown_enable=0,
    overvoltage_shutdown_enable=0, auto_precharge_req=0, auto_charge_req=0, auto_discharge_req=0,
    auto_load_monitor_on=0, auto_load_present=0, auto_charger_monitor_on=0, auto_charger_present=0,
    open_wire_host_enable=0, open_wire_scan_done=0, switches_off_input=0, load_sense_pin=0, charger_sense_pin=0;
  logic reg_wr_en, reg_rd_en, precharge_switch_drive, charge_switch_drive, discharge_switch_drive,
    pack_shutdown_out, load_monitor_on, load_recovery_pulse, load_present_flag, charger_monitor_on,
    charger_recovery_pulse, charger_present_flag, auto_scan_enable, open_wire_scan_req, host_balance_override,
    host_balance_active;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] seed=16'h8D0C;
  int bad_count=0, tests_run=0, m87;
  host_override_control #(.PULSE_CYCLES(2)) host_override_control_inst (.*);
  host_model host_model_inst (.*);
  initial
  begin
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] t;
    t = s ^ (s << 7);
    t = t ^ (t >> 9);
    return t ^ (t << 8);
  endfunction : xs
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host_model_inst.access(1'b0, a, 8'h00);
    chk(reg_rdata, e);
  endtask : rd
  task automatic wait3();
    repeat (3) @(posedge clk);
    #1;
  endtask : wait3
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_model_inst.access(1'b1, a, d);
  endtask : wr
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // hang guard counts as a mismatch
  initial
  begin
    #100000;
    bad_count++;
    final_report();
  end
  initial
  begin
    wait3();
    sys_rst = 1'b0;
    rd(8'h86, 8'h00);
    rd(8'h87, 8'h00);
    rd(8'h55, 8'h00);
    chk({7'h00, auto_scan_enable}, 8'h01);
    $display("reset test done");
    seed = xs(seed);
    m87 = (seed[7:0] & 8'h21) | 8'h40;
    wr(8'h87, m87[7:0] | 8'h80);
    wr(8'h86, 8'h0F);
    wait3();
    chk({4'h0, pack_shutdown_out, precharge_switch_drive, charge_switch_drive, discharge_switch_drive}, 8'h0F);
    chk({6'h00, host_balance_override, host_balance_active}, {6'h00, m87[5], m87[5] & m87[0]});
    rd(8'h87, m87[7:0]);
    discharge_short_circuit = 1'b1;
    wait3();
    chk({4'h0, pack_shutdown_out, precharge_switch_drive, charge_switch_drive, discharge_switch_drive}, 8'h08);
    rd(8'h86, 8'h0F);
    discharge_short_circuit = 1'b0;
    $display("override test done");
    wr(8'h87, 8'h00);
    wr(8'h86, 8'h07);
    charge_overcurrent = 1'b1;
    wait3();
    charge_overcurrent = 1'b0;
    rd(8'h86, 8'h01);
    cell_failure = 1'b1;
    cell_failure_shutdown_enable = 1'b1;
    wait3();
    rd(8'h86, 8'h09);
    chk({7'h00, pack_shutdown_out}, 8'h01);
    $display("automatic test done");
    // host-run monitors: trigger both, then clear each presence flag
    seed = xs(seed);
    load_sense_pin = seed[1];
    charger_sense_pin = seed[2];
    wr(8'h87, 8'h18);
    wr(8'h86, 8'h50);
    chk({4'h0, load_monitor_on, load_recovery_pulse, charger_monitor_on, charger_recovery_pulse}, 8'h0F);
    wait3();
    chk({4'h0, load_monitor_on, load_recovery_pulse, load_present_flag, charger_present_flag},
        {4'h0, 1'b1, 1'b0, seed[1], seed[2]});
    rd(8'h86, 8'h08);
    wr(8'h86, 8'h80);
    chk({4'h0, load_monitor_on, load_present_flag, charger_monitor_on, charger_present_flag},
        {7'h00, seed[2]});
    wr(8'h86, 8'h20);
    chk({7'h00, charger_present_flag}, 8'h00);
    $display("monitor test done");
    // open-wire launch, then watchdog hold released by a bus transaction
    open_wire_host_enable = 1'b1;
    wr(8'h87, 8'h02);
    chk({7'h00, open_wire_scan_req}, 8'h01);
    rd(8'h87, 8'h02);
    open_wire_scan_done = 1'b1;
    tick();
    open_wire_scan_done = 1'b0;
    rd(8'h87, 8'h00);
    wr(8'h87, 8'h04);
    watchdog_expired = 1'b1;
    tick();
    watchdog_expired = 1'b0;
    rd(8'h87, 8'h00);
    chk({7'h00, auto_scan_enable}, 8'h00);
    i2c_transaction = 1'b1;
    tick();
    i2c_transaction = 1'b0;
    chk({7'h00, auto_scan_enable}, 8'h01);
    $display("scan test done");
    final_report();
  end
endmodule : host_override_control_bench
`default_nettype wire
